// ### hdl/rin_pkg.sv
package rin_pkg;
    // Register indexes (printed offsets are not all multiples of four: byte address is index times four)
    localparam logic [8:0] IDX_ADC_RESULT   = 9'h01e;
    localparam logic [8:0] IDX_ADC_CONTROL  = 9'h01f;
    localparam logic [8:0] IDX_OPTION       = 9'h081;
    localparam logic [8:0] IDX_DIR_A        = 9'h085;
    localparam logic [8:0] IDX_DIR_B        = 9'h086;
    localparam logic [8:0] IDX_DIR_C        = 9'h087;
    localparam logic [8:0] IDX_DIR_D        = 9'h088;
    localparam logic [8:0] IDX_DIR_E        = 9'h089;
    localparam logic [8:0] IDX_PIE_FIRST    = 9'h08c;
    localparam logic [8:0] IDX_PIE_SECOND   = 9'h08d;
    localparam logic [8:0] IDX_CAUSE        = 9'h08e;
    localparam logic [8:0] IDX_T1_GATE      = 9'h08f;
    localparam logic [8:0] IDX_OSC_CTRL     = 9'h090;
    localparam logic [8:0] IDX_OSC_TUNE     = 9'h091;
    localparam logic [8:0] IDX_T2_PERIOD    = 9'h092;
    localparam logic [8:0] IDX_SP_ADDR      = 9'h093;
    localparam logic [8:0] IDX_SP_STATUS    = 9'h094;
    localparam logic [8:0] IDX_PULLUP_B     = 9'h095;
    localparam logic [8:0] IDX_CHG_IRQ_B    = 9'h096;
    localparam logic [8:0] IDX_UART_TX      = 9'h098;
    localparam logic [8:0] IDX_UART_BAUD    = 9'h099;
    localparam logic [8:0] IDX_ALT_PIN      = 9'h09c;
    localparam logic [8:0] IDX_FIXED_REF    = 9'h09d;
    localparam logic [8:0] IDX_ADC_CONFIG   = 9'h09f;
    localparam logic [8:0] IDX_CAP_CTRL     = 9'h108;
    localparam logic [8:0] IDX_CAP_CHAN     = 9'h109;
    localparam logic [8:0] IDX_PM_DATA_LO   = 9'h10c;
    localparam logic [8:0] IDX_PM_ADDR_LO   = 9'h10d;
    localparam logic [8:0] IDX_PM_DATA_HI   = 9'h10e;
    localparam logic [8:0] IDX_PM_ADDR_HI   = 9'h10f;
    localparam logic [8:0] IDX_ANSEL_A      = 9'h185;
    localparam logic [8:0] IDX_ANSEL_B      = 9'h186;
    localparam logic [8:0] IDX_ANSEL_D      = 9'h188;
    localparam logic [8:0] IDX_ANSEL_E      = 9'h189;
    localparam logic [8:0] IDX_PM_CTRL      = 9'h18c;
    // Own additions: bank selects the serial mask, core flags, event status and mask
    localparam logic [8:0] IDX_SP_BANK      = 9'h1f0;
    localparam logic [8:0] IDX_CORE_IRQ     = 9'h1f1;
    localparam logic [8:0] IDX_PIR_FIRST    = 9'h1f2;
    localparam logic [8:0] IDX_PIR_SECOND   = 9'h1f3;
    localparam logic [8:0] IDX_EVT_STATUS   = 9'h1f4;
    localparam logic [8:0] IDX_EVT_MASK     = 9'h1f5;
    localparam logic [8:0] IDX_WAKE_PC      = 9'h1f6;

    // Number of stored registers
    localparam int NREG = 40;

    // Fixed reset values and implemented-bit masks
    localparam logic [7:0] RST_ALL_ONES = 8'hff;
    localparam logic [7:0] RST_ZERO     = 8'h00;
    localparam logic [7:0] RST_DIR_E    = 8'h0f;
    localparam logic [7:0] RST_ANSEL_AB = 8'h3f;
    localparam logic [7:0] RST_ANSEL_E  = 8'h07;
    localparam logic [7:0] RST_UART_TX  = 8'h02;
    localparam logic [7:0] RST_OSC      = 8'h20;
    localparam logic [7:0] RST_PM_CTRL  = 8'h80;
    localparam logic [7:0] MSK_ADC_CTRL = 8'h3f;
    localparam logic [7:0] MSK_PERIPH_IRQ_ENABLE_SECOND     = 8'h01;
    localparam logic [7:0] MSK_CAUSE    = 8'h03;
    localparam logic [7:0] MSK_OSC      = 8'h3c;
    localparam logic [7:0] MSK_OSC_TUNE = 8'h3f;
    localparam logic [7:0] MSK_UART_TX  = 8'hf7;
    localparam logic [7:0] MSK_ALT_PIN  = 8'h03;
    localparam logic [7:0] MSK_FIXREF   = 8'hf3;
    localparam logic [7:0] MSK_ADC_CFG  = 8'h77;
    localparam logic [7:0] MSK_CAP_CTL  = 8'h8f;
    localparam logic [7:0] MSK_CAP_CHN  = 8'h0f;
    localparam logic [7:0] MSK_PM_DH    = 8'h3f;
    localparam logic [7:0] MSK_PM_AH    = 8'h1f;
    localparam logic [7:0] MSK_PM_CTRL  = 8'h81;
    localparam logic [7:0] MSK_T1_GATE  = 8'hfb;

    // Field positions
    localparam int CAUSE_BROWN_BIT = 0;
    localparam int CAUSE_POWER_BIT = 1;
    localparam int GIE_BIT         = 7;
    localparam int OSC_STABLE_BIT  = 0;
    localparam int OSC_LOCK_BIT    = 1;
    localparam int FVR_READY_BIT   = 6;
    localparam int T1G_VALUE_BIT   = 2;

    // Event status bits
    localparam int EVT_POWER = 0;
    localparam int EVT_PIN   = 1;
    localparam int EVT_WAKE  = 2;
    localparam int EVT_VEC   = 3;

    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // Kind of reset or wake event asked of the block
    typedef enum logic [2:0] {
        RIN_EV_NONE, RIN_EV_POR, RIN_EV_BOR, RIN_EV_PIN, RIN_EV_WDT, RIN_EV_WAKE_IRQ, RIN_EV_WAKE_WDT
    } rin_event_t;

    // Wake request with its source flags
    typedef struct packed {
        logic       valid;
        logic [7:0] coreFlags;
        logic [7:0] pirFirst;
        logic [7:0] pirSecond;
    } rin_wake_t;

    // Live hardware state that feeds condition-dependent bits
    typedef struct packed {
        logic oscStable;
        logic oscLocked;
        logic refReady;
        logic gateValue;
    } rin_hwstat_t;
endpackage

// ### hdl/rin_reset_init.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module rin_reset_init (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire logic                 supplyLow,
    input  wire rin_pkg::rin_event_t  resetEvent,
    input  wire rin_pkg::rin_wake_t   wakeReq,
    input  wire rin_pkg::rin_hwstat_t hwStatRaw,
    output logic                      vectorLoad,
    output logic [12:0]               vectorAddr,
    output logic                      irq
);
    ////////////////////////////////////////////////////////////////////////////////
    // Synchronise the live status pins and supply monitor
    rin_pkg::rin_hwstat_t hwMeta_q;
    rin_pkg::rin_hwstat_t hwStat_q;
    logic                 lowMeta_q;
    logic                 supplyLow_q;
    rin_pkg::rin_hwstat_t hwMeta;
    logic                 lowMeta;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hwMeta_q    <= '0;
            hwStat_q    <= '0;
            lowMeta_q   <= 1'b0;
            supplyLow_q <= 1'b0;
        end else begin
            hwMeta_q    <= hwStatRaw;
            hwStat_q    <= hwMeta;
            lowMeta_q   <= supplyLow;
            supplyLow_q <= lowMeta;
        end
    end
    assign hwMeta  = hwMeta_q;
    assign lowMeta = lowMeta_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Event decode; a low supply outranks whatever reset was asked
    logic isPowerOn;
    logic isBrown;
    logic isPinDog;
    logic isWake;
    logic isWakeIrq;
    logic fullLoad;
    assign isBrown   = (resetEvent == rin_pkg::RIN_EV_BOR) || supplyLow_q;
    assign isPowerOn = (resetEvent == rin_pkg::RIN_EV_POR) && !isBrown;
    assign isPinDog  = ((resetEvent == rin_pkg::RIN_EV_PIN) || (resetEvent == rin_pkg::RIN_EV_WDT)) && !isBrown
                       && !isPowerOn;
    assign isWakeIrq = (resetEvent == rin_pkg::RIN_EV_WAKE_IRQ) && !supplyLow_q;
    assign isWake    = (isWakeIrq || (resetEvent == rin_pkg::RIN_EV_WAKE_WDT)) && !supplyLow_q;
    assign fullLoad  = isPowerOn || isBrown || isPinDog;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map: slot table of index, reset value, implemented mask, loaded flag
    localparam int N = rin_pkg::NREG;
    localparam logic [8:0] SLOT_IDX [N] = '{
        rin_pkg::IDX_ADC_RESULT,
        rin_pkg::IDX_ADC_CONTROL,
        rin_pkg::IDX_OPTION,
        rin_pkg::IDX_DIR_A,
        rin_pkg::IDX_DIR_B,
        rin_pkg::IDX_DIR_C,
        rin_pkg::IDX_DIR_D,
        rin_pkg::IDX_DIR_E,
        rin_pkg::IDX_PIE_FIRST,
        rin_pkg::IDX_PIE_SECOND,
        rin_pkg::IDX_CAUSE, // Slot 10, handled apart
        rin_pkg::IDX_T1_GATE, // Slot 11, held on pin reset
        rin_pkg::IDX_OSC_CTRL,
        rin_pkg::IDX_OSC_TUNE, // Slot 13, held on pin reset
        rin_pkg::IDX_T2_PERIOD,
        rin_pkg::IDX_SP_ADDR, // Slot 15, bank bit clear
        rin_pkg::IDX_SP_ADDR, // Slot 16, bank bit set
        rin_pkg::IDX_SP_STATUS,
        rin_pkg::IDX_PULLUP_B,
        rin_pkg::IDX_CHG_IRQ_B,
        rin_pkg::IDX_UART_TX,
        rin_pkg::IDX_UART_BAUD,
        rin_pkg::IDX_ALT_PIN,
        rin_pkg::IDX_FIXED_REF,
        rin_pkg::IDX_ADC_CONFIG,
        rin_pkg::IDX_CAP_CTRL,
        rin_pkg::IDX_CAP_CHAN,
        rin_pkg::IDX_PM_DATA_LO,
        rin_pkg::IDX_PM_ADDR_LO,
        rin_pkg::IDX_PM_DATA_HI,
        rin_pkg::IDX_PM_ADDR_HI,
        rin_pkg::IDX_ANSEL_A,
        rin_pkg::IDX_ANSEL_B,
        rin_pkg::IDX_ANSEL_D,
        rin_pkg::IDX_ANSEL_E,
        rin_pkg::IDX_PM_CTRL,
        rin_pkg::IDX_SP_BANK,
        rin_pkg::IDX_CORE_IRQ,
        rin_pkg::IDX_PIR_FIRST,
        rin_pkg::IDX_PIR_SECOND
    };
    localparam logic [7:0] SLOT_RST [N] = '{
        8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00, 8'hff, 8'h00,
        8'hff, 8'h00, 8'hff, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3f,
        8'h3f, 8'hff, 8'h07, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00
    };
    localparam logic [7:0] SLOT_MSK [N] = '{
        8'hff, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f,
        8'hff, 8'h01, 8'h03, 8'hfb, 8'h3c, 8'h3f, 8'hff, 8'hff,
        8'hff, 8'hff, 8'hff, 8'hff, 8'hf7, 8'hff, 8'h03, 8'hf3,
        8'h77, 8'h8f, 8'h0f, 8'hff, 8'hff, 8'h3f, 8'h1f, 8'h3f,
        8'h3f, 8'hff, 8'h07, 8'h81, 8'h01, 8'hff, 8'hff, 8'h01
    };
    // Slots with unknown-on-reset contents, plus the cause register that is handled apart
    localparam logic [N-1:0] SLOT_KEEP = 40'h00_7800_0401;
    // Oscillator tuning and timer gate keep their contents across pin and watchdog resets
    localparam logic [N-1:0] SLOT_LOAD_PIN = ~SLOT_KEEP & ~(40'h1 << 13) & ~(40'h1 << 11);
    localparam int S_CAUSE = 10;
    localparam int S_GATE  = 11;
    localparam int S_OSC   = 12;
    localparam int S_MASK  = 16;
    localparam int S_SPADR = 15;
    localparam int S_FIXR  = 23;
    localparam int S_BANK  = 36;
    localparam int S_CORE  = 37;
    localparam int S_PERIPH_IRQ_FLAGS_FIRST  = 38;
    localparam int S_PERIPH_IRQ_FLAGS_SECOND  = 39;

    logic [7:0] regs_q [N];
    logic [4:0] evtStat_q;
    logic [4:0] evtMask_q;
    logic [12:0] wakePc_q;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode, single-cycle answer; word aligned for slot registers only, unmapped gives pslverr
    logic        apbWrite;
    logic        apbAccess;
    logic [8:0]  regIdx;
    logic [N-1:0] hitVec;
    logic        hitStatus;
    logic        hitMask;
    logic        hitPc;
    logic        hitAny;
    assign apbAccess = psel && penable;
    assign apbWrite  = apbAccess && pwrite && pstrb[0];
    assign regIdx    = paddr[10:2];
    assign hitStatus = regIdx == rin_pkg::IDX_EVT_STATUS;
    assign hitMask   = regIdx == rin_pkg::IDX_EVT_MASK;
    assign hitPc     = regIdx == rin_pkg::IDX_WAKE_PC;

    // Shared address: bank bit steers between serial address and mask
    always_comb begin
        for (int i = 0; i < N; i++) begin
            hitVec[i] = (regIdx == SLOT_IDX[i]) && (paddr[1:0] == 2'b00) && !paddr[11];
        end
        hitVec[S_SPADR] = hitVec[S_SPADR] && !regs_q[S_BANK][0];
        hitVec[S_MASK]  = hitVec[S_MASK] && regs_q[S_BANK][0];
    end
    assign hitAny  = (|hitVec) || hitStatus || hitMask || hitPc;
    assign pready  = 1'b1;
    assign pslverr = apbAccess && !hitAny;

    // Read value with live condition bits folded in
    function automatic logic [7:0] rin_view(input int s, input logic [7:0] v, input rin_pkg::rin_hwstat_t h);
        logic [7:0] r;
        r = v & SLOT_MSK[s];
        if (s == S_OSC) begin
            r[rin_pkg::OSC_STABLE_BIT] = h.oscStable;
            r[rin_pkg::OSC_LOCK_BIT]   = h.oscLocked;
        end
        if (s == S_FIXR) begin
            r[rin_pkg::FVR_READY_BIT] = h.refReady;
        end
        if (s == S_GATE) begin
            r[rin_pkg::T1G_VALUE_BIT] = h.gateValue;
        end
        return r;
    endfunction

    logic [7:0] readByte;
    always_comb begin
        readByte = 8'h00;
        for (int i = 0; i < N; i++) begin
            if (hitVec[i]) readByte = rin_view(i, regs_q[i], hwStat_q);
        end
        if (hitStatus) readByte = {3'b000, evtStat_q};
        if (hitMask)   readByte = {3'b000, evtMask_q};
        if (hitPc)     readByte = wakePc_q[7:0];
    end

    // Read data loaded in the setup cycle, so it already stands when pready is sampled in the access phase
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata <= {24'h00_0000, readByte};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage; resets overrule software, wake keeps all but flags
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < N; i++) regs_q[i] <= SLOT_RST[i];
        end else if (isPowerOn || isBrown) begin
            for (int i = 0; i < N; i++) begin
                if (!SLOT_KEEP[i]) regs_q[i] <= SLOT_RST[i];
            end
            regs_q[S_CAUSE][rin_pkg::CAUSE_POWER_BIT] <= 1'b1;
            regs_q[S_CAUSE][rin_pkg::CAUSE_BROWN_BIT] <= !isBrown;
        end else if (isPinDog) begin
            for (int i = 0; i < N; i++) begin
                if (SLOT_LOAD_PIN[i]) regs_q[i] <= SLOT_RST[i];
            end
        end else if (isWake) begin
            // Contents held; only interrupt wakes raise flags
            if (isWakeIrq && wakeReq.valid) begin
                regs_q[S_CORE] <= regs_q[S_CORE] | wakeReq.coreFlags;
                regs_q[S_PERIPH_IRQ_FLAGS_FIRST] <= regs_q[S_PERIPH_IRQ_FLAGS_FIRST] | wakeReq.pirFirst;
                regs_q[S_PERIPH_IRQ_FLAGS_SECOND] <= regs_q[S_PERIPH_IRQ_FLAGS_SECOND] | (wakeReq.pirSecond & SLOT_MSK[S_PERIPH_IRQ_FLAGS_SECOND]);
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (apbWrite && hitVec[i]) regs_q[i] <= pwdata[7:0] & SLOT_MSK[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Vector load on interrupt wake with global enable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            vectorLoad <= 1'b0;
            vectorAddr <= 13'h0000;
            wakePc_q   <= 13'h0000;
        end else begin
            vectorLoad <= isWakeIrq && regs_q[S_CORE][rin_pkg::GIE_BIT];
            if (isWakeIrq && regs_q[S_CORE][rin_pkg::GIE_BIT]) begin
                vectorAddr <= rin_pkg::IRQ_VECTOR;
                wakePc_q   <= rin_pkg::IRQ_VECTOR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Event status, write one to clear; a new event beats the clear
    logic [4:0] evtSet;
    assign evtSet = {1'b0, isWakeIrq && regs_q[S_CORE][rin_pkg::GIE_BIT], isWake, isPinDog, isPowerOn || isBrown};
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evtStat_q <= 5'h00;
            evtMask_q <= 5'h00;
        end else begin
            evtStat_q <= (evtStat_q & ~((apbWrite && hitStatus) ? pwdata[4:0] : 5'h00)) | evtSet;
            if (apbWrite && hitMask) evtMask_q <= pwdata[4:0];
        end
    end
    assign irq = |(evtStat_q & evtMask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_brown_clears_cause;
        @(posedge ref_clk) disable iff (!rstn) isBrown |=> !regs_q[S_CAUSE][rin_pkg::CAUSE_BROWN_BIT];
    endproperty
    a_brown_clears_cause: assert property (p_brown_clears_cause) else $error("brown-out left cause bit set");

    property p_pin_keeps_cause;
        @(posedge ref_clk) disable iff (!rstn) isPinDog |=> $stable(regs_q[S_CAUSE]);
    endproperty
    a_pin_keeps_cause: assert property (p_pin_keeps_cause) else $error("pin reset changed cause");

    property p_low_full_load;
        @(posedge ref_clk) disable iff (!rstn) supplyLow_q |=> regs_q[2] == 8'hff && regs_q[S_CAUSE][1];
    endproperty
    a_low_full_load: assert property (p_low_full_load) else $error("low supply did not load");

    property p_vector;
        @(posedge ref_clk) disable iff (!rstn)
            isWakeIrq && regs_q[S_CORE][7] |=> vectorLoad && vectorAddr == 13'h0004;
    endproperty
    a_vector: assert property (p_vector) else $error("vector not loaded");

    property p_wake_flags;
        @(posedge ref_clk) disable iff (!rstn)
            isWakeIrq && wakeReq.valid |=> (regs_q[S_PERIPH_IRQ_FLAGS_FIRST] & $past(wakeReq.pirFirst)) == $past(wakeReq.pirFirst);
    endproperty
    a_wake_flags: assert property (p_wake_flags) else $error("wake flag not set");

    property p_wake_keeps;
        @(posedge ref_clk) disable iff (!rstn) isWake |=> $stable(regs_q[3]) && $stable(regs_q[14]);
    endproperty
    a_wake_keeps: assert property (p_wake_keeps) else $error("wake changed a register");

    property p_unknown_kept;
        @(posedge ref_clk) disable iff (!rstn) fullLoad |=> $stable(regs_q[0]) && $stable(regs_q[27]);
    endproperty
    a_unknown_kept: assert property (p_unknown_kept) else $error("unknown register loaded");

    property p_pin_values;
        @(posedge ref_clk) disable iff (!rstn)
            isPinDog |=> regs_q[S_SPADR] == 8'h00 && regs_q[S_MASK] == 8'hff && regs_q[7] == 8'h0f;
    endproperty
    a_pin_values: assert property (p_pin_values) else $error("reset values wrong");

    property p_zero_bits;
        @(posedge ref_clk) disable iff (!rstn) (regs_q[9] & ~8'h01) == 8'h00 ##1 (regs_q[7] & 8'hf0) == 8'h00;
    endproperty
    a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bit set");

    // Held registers, vector suppression and timeout wakes
    property p_pin_keeps_gate;
        @(posedge ref_clk) disable iff (!rstn) isPinDog |=> $stable(regs_q[S_GATE]) && $stable(regs_q[13]);
    endproperty
    a_pin_keeps_gate: assert property (p_pin_keeps_gate) else $error("pin reset changed a held register");

    property p_no_enable_no_vector;
        @(posedge ref_clk) disable iff (!rstn) isWakeIrq && !regs_q[S_CORE][7] |=> !vectorLoad;
    endproperty
    a_no_enable_no_vector: assert property (p_no_enable_no_vector) else $error("vector without enable");

    property p_timeout_wake_flags;
        @(posedge ref_clk) disable iff (!rstn)
            isWake && !isWakeIrq |=> $stable(regs_q[S_CORE]) && $stable(regs_q[S_PERIPH_IRQ_FLAGS_FIRST]);
    endproperty
    a_timeout_wake_flags: assert property (p_timeout_wake_flags) else $error("timeout wake set flags");
endmodule

// ### verification/tb_rin_reset_init.sv
`timescale 1ns/100ps
module tb_rin_reset_init;
    logic                  ref_clk;
    logic                  rstn;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [3:0]            pstrb;
    logic                  pready;
    logic [31:0]           prdata;
    logic                  pslverr;
    logic                  supplyLow;
    rin_pkg::rin_event_t   resetEvent;
    rin_pkg::rin_wake_t    wakeReq;
    rin_pkg::rin_hwstat_t  hwStatRaw;
    logic                  vectorLoad;
    logic [12:0]           vectorAddr;
    logic                  irq;
    logic                  lastErr;
    logic [7:0]            d;
    logic [7:0]            nVec = 8'h00;
    int                    n_errors = 0;
    int                    n_tests = 0;
    int                    k;

    // Registers that every reset kind except a wake reloads, with their implemented bits
    localparam logic [8:0] T_IDX [12] = '{rin_pkg::IDX_OPTION, rin_pkg::IDX_DIR_A, rin_pkg::IDX_DIR_B,
        rin_pkg::IDX_DIR_E, rin_pkg::IDX_PIE_SECOND, rin_pkg::IDX_T2_PERIOD, rin_pkg::IDX_SP_ADDR,
        rin_pkg::IDX_PULLUP_B, rin_pkg::IDX_ANSEL_A, rin_pkg::IDX_ANSEL_E, rin_pkg::IDX_ADC_CONTROL,
        rin_pkg::IDX_ANSEL_D};
    localparam logic [7:0] T_RST [12] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h00, 8'hff, 8'h00, 8'hff, 8'h3f, 8'h07,
        8'h00, 8'hff};
    localparam logic [7:0] T_MSK [12] = '{8'hff, 8'hff, 8'hff, 8'h0f, 8'h01, 8'hff, 8'hff, 8'hff, 8'h3f, 8'h07,
        8'h3f, 8'hff};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, design and pulse counter
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    rin_reset_init u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .supplyLow(supplyLow), .resetEvent(resetEvent), .wakeReq(wakeReq), .hwStatRaw(hwStatRaw),
        .vectorLoad(vectorLoad), .vectorAddr(vectorAddr), .irq(irq));

    // Count vector pulses so a double pulse is seen, not just a level
    always @(posedge ref_clk) begin
        if (vectorLoad === 1'b1) nVec <= nVec + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic print_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic [8:0] idx, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {1'b0, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
        lastErr = pslverr;
        rd = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge so that a write has landed before anything is compared
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [8:0] idx, input logic [7:0] v);
        logic [7:0] x;
        apb(idx, 1'b1, v, x);
    endtask

    task automatic rc(input logic [8:0] idx, input logic [7:0] exp);
        logic [7:0] x;
        apb(idx, 1'b0, 8'h00, x);
        check($sformatf("reg %h", idx), exp, x);
    endtask

    // A reset or wake request held for one cycle, then time to settle
    task automatic evt(input rin_pkg::rin_event_t e);
        @(posedge ref_clk);
        resetEvent <= e;
        @(posedge ref_clk);
        resetEvent <= rin_pkg::RIN_EV_NONE;
        repeat (4) @(posedge ref_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        pstrb = 4'h1;
        supplyLow = 1'b0;
        resetEvent = rin_pkg::RIN_EV_NONE;
        wakeReq = '0;
        hwStatRaw = '0;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        for (k = 0; k < 12; k++) rc(T_IDX[k], T_RST[k]);
        rc(rin_pkg::IDX_UART_TX, 8'h02);
        // Mask and address share one place; the bank bit picks which one is seen
        wr(rin_pkg::IDX_SP_BANK, 8'h01);
        rc(rin_pkg::IDX_SP_ADDR, 8'hff);
        wr(rin_pkg::IDX_SP_ADDR, 8'ha5);
        wr(rin_pkg::IDX_SP_BANK, 8'h00);
        rc(rin_pkg::IDX_SP_ADDR, 8'h00);
        for (k = 0; k < 12; k++) wr(T_IDX[k], 8'h55);
        wr(rin_pkg::IDX_PM_DATA_LO, 8'h3c);
        wr(rin_pkg::IDX_T1_GATE, 8'h10);
        wr(rin_pkg::IDX_CAUSE, 8'h03);
        evt(rin_pkg::RIN_EV_WAKE_WDT);
        for (k = 0; k < 12; k++) rc(T_IDX[k], 8'h55 & T_MSK[k]);
        evt(rin_pkg::RIN_EV_PIN);
        for (k = 0; k < 12; k++) rc(T_IDX[k], T_RST[k]);
        rc(rin_pkg::IDX_PM_DATA_LO, 8'h3c);
        rc(rin_pkg::IDX_T1_GATE, 8'h10);
        // A write with its byte strobe low must leave the register alone
        pstrb <= 4'h0;
        wr(rin_pkg::IDX_DIR_B, 8'h00);
        pstrb <= 4'h1;
        rc(rin_pkg::IDX_DIR_B, 8'hff);
        apb(rin_pkg::IDX_CAUSE, 1'b0, 8'h00, d);
        check("cause bit0 after pin reset", 8'h01, {7'h00, d[0]});
        evt(rin_pkg::RIN_EV_BOR);
        apb(rin_pkg::IDX_CAUSE, 1'b0, 8'h00, d);
        check("cause bit0 after brown-out", 8'h00, {7'h00, d[0]});
        wr(rin_pkg::IDX_DIR_C, 8'h00);
        wr(rin_pkg::IDX_OSC_TUNE, 8'h2a);
        evt(rin_pkg::RIN_EV_WDT);
        rc(rin_pkg::IDX_DIR_C, 8'hff);
        rc(rin_pkg::IDX_OSC_TUNE, 8'h2a);
        evt(rin_pkg::RIN_EV_POR);
        rc(rin_pkg::IDX_OSC_TUNE, 8'h00);
        // Supply drop during a pin reset must give the full brown-out load
        wr(rin_pkg::IDX_DIR_A, 8'h00);
        wr(rin_pkg::IDX_OSC_TUNE, 8'h15);
        wr(rin_pkg::IDX_CAUSE, 8'h01);
        @(posedge ref_clk);
        supplyLow <= 1'b1;
        resetEvent <= rin_pkg::RIN_EV_PIN;
        repeat (6) @(posedge ref_clk);
        supplyLow <= 1'b0;
        resetEvent <= rin_pkg::RIN_EV_NONE;
        repeat (6) @(posedge ref_clk);
        rc(rin_pkg::IDX_DIR_A, 8'hff);
        rc(rin_pkg::IDX_OSC_TUNE, 8'h00);
        apb(rin_pkg::IDX_CAUSE, 1'b0, 8'h00, d);
        check("cause bit0 after supply drop", 8'h00, {7'h00, d[0]});
        for (k = 1; k >= 0; k--) begin
            hwStatRaw.oscStable <= k[0];
            repeat (4) @(posedge ref_clk);
            apb(rin_pkg::IDX_OSC_CTRL, 1'b0, 8'h00, d);
            check("oscillator stable bit", {7'h00, k[0]}, {7'h00, d[0]});
        end
        // Wake by interrupt with the global enable set
        wr(rin_pkg::IDX_EVT_STATUS, 8'h0f);
        wr(rin_pkg::IDX_EVT_MASK, 8'h04);
        check("irq idle", 8'h00, {7'h00, irq});
        wr(rin_pkg::IDX_CORE_IRQ, 8'h80);
        wakeReq <= {1'b1, 8'h02, 8'h10, 8'h01};
        evt(rin_pkg::RIN_EV_WAKE_IRQ);
        check("vector pulses", 8'h01, nVec);
        check("vector low", 8'h04, vectorAddr[7:0]);
        check("vector high", 8'h00, {3'b000, vectorAddr[12:8]});
        rc(rin_pkg::IDX_PIR_FIRST, 8'h10);
        rc(rin_pkg::IDX_PIR_SECOND, 8'h01);
        apb(rin_pkg::IDX_CORE_IRQ, 1'b0, 8'h00, d);
        check("core wake flag", 8'h02, d & 8'h02);
        check("irq raised", 8'h01, {7'h00, irq});
        wr(rin_pkg::IDX_EVT_MASK, 8'h00);
        check("irq masked", 8'h00, {7'h00, irq});
        wr(rin_pkg::IDX_EVT_MASK, 8'h04);
        wr(rin_pkg::IDX_EVT_STATUS, 8'h04);
        check("irq cleared", 8'h00, {7'h00, irq});
        // Without the global enable a wake must not vector
        wr(rin_pkg::IDX_CORE_IRQ, 8'h00);
        evt(rin_pkg::RIN_EV_WAKE_IRQ);
        check("vector pulses no enable", 8'h01, nVec);
        apb(9'h1ff, 1'b0, 8'h00, d);
        check("unmapped error", 8'h01, {7'h00, lastErr});
        check("unmapped data", 8'h00, d);
        print_verdict();
    end
endmodule
